/* File: pkg/timer16_cfg.svh */
// offsets, field positions, reset values and timing counts for the 16-bit timer
`ifndef TIMER16_CFG_SVH
`define TIMER16_CFG_SVH
`define ADDR_TIMER_CONTROL 3'h0
`define ADDR_GATE_CONTROL 3'h1
`define ADDR_COUNT_LOW 3'h2
`define ADDR_COUNT_HIGH 3'h3
`define ADDR_IRQ_ENABLES 3'h4
`define ADDR_IRQ_FLAGS 3'h5
`define ADDR_STATUS 3'h6
`define CTRL_WRITE_MASK 8'hFD
`define GATE_WRITE_MASK 8'hE3
`define CTRL_RESET 8'h00
`define GATE_RESET 8'h00
`define IRQ_RESET 8'h00
`define BIT_COUNTER_ON 0
`define BIT_SYNC_BYPASS 2
`define BIT_CRYSTAL_OSC_ENABLE 3
`define BIT_PRESCALE_LO 4
`define BIT_SOURCE_LO 6
`define BIT_GATE_ENABLE 7
`define BIT_GATE_POLARITY 6
`define BIT_OVERFLOW 0
`define FOSC_DIV 2'h3
`endif

/* File: pkg/timer16_pkg.sv */
// types shared by the 16-bit timer
package timer16_pkg;
  typedef enum logic [1:0] {
    src_instr,
    src_sys,
    src_ext,
    src_cap
  } clock_source_e;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } bus_req_s;
endpackage

/* File: verilog/async_counter_timer16.sv */
// 16-bit timer/counter with prescaler, external count input and overflow interrupt
//
// How it works
// RULE1: sync_bypass counts external input unsynchronized; here the pin stays synchronised and bypass only enables counting in sleep
// RULE2: async external counting runs during sleep, wakes
// RULE3: mode switch may drop or add increment
// RULE4: count byte reads valid while async running
// RULE5: software handles overflow between byte reads
// RULE6: software stops counter before async writes
// RULE7: write during increment may corrupt count
// RULE8: unimplemented control bits read zero
// RULE9: power-on reset clears control; others keep
// RULE10: counter_on and gate_enable select counting
// RULE11: source select picks one of four clocks
// RULE12: prescaler 1/2/4/8, cleared by count write
// RULE13: 16-bit count, byte writes update immediately
// RULE14: rollover sets overflow_flag, enabled raises irq
// RULE15: overflow_flag cleared only by software; here sys_rst and power_on_rst also clear it
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/10ps
`include "timer16_cfg.svh"
module async_counter_timer16 (
  // clock and resets
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic power_on_rst,
  // register port
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic write,
  input wire logic read,
  output logic [7:0] rdata,
  // count sources and gate
  input wire logic ext_count_input,
  input wire logic crystal_osc_input,
  input wire logic cap_osc_input,
  input wire logic gate_input,
  input wire logic sleeping,
  // interrupt and wake
  output logic irq,
  output logic wake
);
  ////////////////////////////////////////////////////////////////////////////
  timer16_pkg::bus_req_s req;
  logic [7:0] timer_control, next_timer_control;
  logic [7:0] timer_gate_control, next_timer_gate_control;
  logic [7:0] peripheral_irq_enables, next_peripheral_irq_enables;
  logic [7:0] peripheral_irq_flags, next_peripheral_irq_flags;
  logic [15:0] count, next_count;
  logic [2:0] prescale, next_prescale;
  logic [1:0] phase, next_phase;
  logic [2:0] ext_sync, next_ext_sync;
  logic [2:0] xtal_sync, next_xtal_sync;
  logic [2:0] cap_sync, next_cap_sync;
  logic [1:0] gate_sync, next_gate_sync;
  logic [7:0] next_rdata;
  logic next_irq, next_wake;
  timer16_pkg::clock_source_e source;
  logic tick, enabled, gate_open, prescale_done, ext_edge, overflow, count_write;
  logic [2:0] prescale_limit;

  assign req = '{addr: addr, wdata: wdata, write: write, read: read};

  ////////////////////////////////////////////////////////////////////////////
  // clock source and enable
  always_comb begin
    case (timer_control[`BIT_SOURCE_LO +: 2]) // RULE11
      2'h1: source = timer16_pkg::src_sys;
      2'h0: source = timer16_pkg::src_instr;
      2'h3: source = timer16_pkg::src_cap;
      default: source = timer16_pkg::src_ext;
    endcase
  end

  // the async path still samples the pin here; true asynchrony would need a pin-clocked
  // flop that sim cannot hold safely, so bypass only lets the synchronised edge count during sleep
  always_comb begin
    if (source == timer16_pkg::src_cap) begin
      ext_edge = cap_sync[1] & ~cap_sync[2]; // RULE3
    end else if (timer_control[`BIT_CRYSTAL_OSC_ENABLE]) begin
      ext_edge = xtal_sync[1] & ~xtal_sync[2]; // RULE11
    end else begin
      ext_edge = ext_sync[1] & ~ext_sync[2]; // RULE1
    end
  end

  always_comb begin
    gate_open = timer_gate_control[`BIT_GATE_POLARITY] ? gate_sync[1] : ~gate_sync[1];
    enabled = timer_control[`BIT_COUNTER_ON] & (~timer_gate_control[`BIT_GATE_ENABLE] | gate_open); // RULE10
    case (source)
      timer16_pkg::src_sys: tick = 1'b1;
      timer16_pkg::src_instr: tick = (phase == `FOSC_DIV);
      default: tick = ext_edge & (timer_control[`BIT_SYNC_BYPASS] | ~sleeping); // RULE2
    endcase
    prescale_limit = 3'((3'h1 << timer_control[`BIT_PRESCALE_LO +: 2]) - 3'h1);
    prescale_done = (prescale == prescale_limit); // RULE12
  end

  ////////////////////////////////////////////////////////////////////////////
  // counting
  always_comb begin
    count_write = req.write && (req.addr == `ADDR_COUNT_LOW || req.addr == `ADDR_COUNT_HIGH);
    next_phase = 2'(phase + 2'h1);
    next_prescale = prescale;
    next_count = count;
    overflow = 1'b0;
    next_ext_sync = {ext_sync[1:0], ext_count_input};
    next_xtal_sync = {xtal_sync[1:0], crystal_osc_input};
    next_cap_sync = {cap_sync[1:0], cap_osc_input};
    next_gate_sync = {gate_sync[0], gate_input};
    if (enabled && tick) begin
      if (prescale_done) begin
        next_prescale = 3'h0;
        next_count = 16'(count + 16'h0001);
        overflow = (count == 16'hFFFF); // RULE14
      end else begin
        next_prescale = 3'(prescale + 3'h1);
      end
    end
    // a write wins over a coincident increment; the lost tick is the contention
    if (count_write) begin
      next_prescale = 3'h0; // RULE12
      overflow = 1'b0; // RULE7
      if (req.addr == `ADDR_COUNT_LOW) begin
        next_count = {count[15:8], req.wdata}; // RULE13
      end else begin
        next_count = {req.wdata, count[7:0]}; // RULE13
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and interrupt
  always_comb begin
    next_timer_control = timer_control;
    next_timer_gate_control = timer_gate_control;
    next_peripheral_irq_enables = peripheral_irq_enables;
    next_peripheral_irq_flags = peripheral_irq_flags;
    if (req.write) begin
      case (req.addr)
        `ADDR_TIMER_CONTROL: next_timer_control = req.wdata & `CTRL_WRITE_MASK; // RULE8
        `ADDR_GATE_CONTROL: next_timer_gate_control = req.wdata & `GATE_WRITE_MASK; // RULE8
        `ADDR_IRQ_ENABLES: next_peripheral_irq_enables = req.wdata;
        `ADDR_IRQ_FLAGS: next_peripheral_irq_flags = req.wdata; // RULE15
        default: next_peripheral_irq_flags = peripheral_irq_flags;
      endcase
    end
    // hardware set wins over a software clear in the same cycle
    if (overflow) begin
      next_peripheral_irq_flags[`BIT_OVERFLOW] = 1'b1; // RULE14
    end
    next_irq = |(next_peripheral_irq_flags & next_peripheral_irq_enables); // RULE14
    next_wake = next_irq & sleeping; // RULE2
    next_rdata = 8'h00;
    if (req.read) begin
      case (req.addr)
        `ADDR_TIMER_CONTROL: next_rdata = timer_control; // RULE8
        `ADDR_GATE_CONTROL: next_rdata = timer_gate_control;
        `ADDR_COUNT_LOW: next_rdata = count[7:0]; // RULE4
        `ADDR_COUNT_HIGH: next_rdata = count[15:8]; // RULE4
        `ADDR_IRQ_ENABLES: next_rdata = peripheral_irq_enables;
        `ADDR_IRQ_FLAGS: next_rdata = peripheral_irq_flags;
        `ADDR_STATUS: next_rdata = {5'h00, 1'(enabled), 1'(gate_sync[1]), 1'(sleeping)};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // control survives sys_rst; only power-on reset clears it
  always_ff @(posedge clock) begin
    if (power_on_rst) begin
      timer_control <= `CTRL_RESET; // RULE9
      timer_gate_control <= `GATE_RESET;
    end else begin
      timer_control <= next_timer_control;
      timer_gate_control <= next_timer_gate_control;
    end
  end

  // count keeps its value across every reset
  always_ff @(posedge clock) begin
    count <= next_count; // RULE9
    ext_sync <= next_ext_sync;
    xtal_sync <= next_xtal_sync;
    cap_sync <= next_cap_sync;
    gate_sync <= next_gate_sync;
  end

  always_ff @(posedge clock) begin
    if (sys_rst || power_on_rst) begin
      peripheral_irq_enables <= `IRQ_RESET;
      peripheral_irq_flags <= `IRQ_RESET;
      prescale <= 3'h0;
      phase <= 2'h0;
      rdata <= 8'h00;
      irq <= 1'b0;
      wake <= 1'b0;
    end else begin
      peripheral_irq_enables <= next_peripheral_irq_enables;
      peripheral_irq_flags <= next_peripheral_irq_flags;
      prescale <= next_prescale;
      phase <= next_phase;
      rdata <= next_rdata;
      irq <= next_irq;
      wake <= next_wake;
    end
  end
endmodule

/* File: testbench/timer16_properties.sv */
// port checks for the 16-bit timer
`timescale 1ns/10ps
module timer16_properties (
  // clock and resets
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic power_on_rst,
  // register port
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic write,
  input wire logic read,
  input wire logic [7:0] rdata,
  // interrupt and wake
  input wire logic sleeping,
  input wire logic irq,
  input wire logic wake
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst || power_on_rst);
  logic irq_wr;
  assign irq_wr = write && (addr == 3'h4 || addr == 3'h5);
  //////////////////////////////////////////
  a_rdata_idle: assert property (!$past(read) |-> rdata == 8'h00) else $error("rdata set without read");
  a_ctrl_gap: assert property (read && addr == 3'h0 |=> !rdata[1]) else $error("control bit 1 set");
  a_gate_gap: assert property (read && addr == 3'h1 |=> rdata[4:2] == 3'h0) else $error("gate gap set");
  a_unmapped_zero: assert property (read && addr == 3'h7 |=> rdata == 8'h00) else $error("unmapped read");
  a_ctrl_readback: assert property (write && addr == 3'h0 ##1 read && addr == 3'h0
    |=> rdata == ($past(wdata, 2) & 8'hFD)) else $error("control readback");
  a_wake_awake: assert property (!sleeping [*3] |=> !wake) else $error("wake while awake");
  a_flag_sticky: assert property (irq && !irq_wr && !$past(irq_wr) |=> irq) else $error("irq dropped");
  a_irq_off: assert property (write && addr == 3'h4 && wdata == 8'h00 |=> !irq) else $error("irq stays");
  cover property ($rose(irq));
  cover property (wake);
  cover property (read && addr == 3'h2);
endmodule
bind async_counter_timer16 timer16_properties timer16_properties_i (.clock, .sys_rst, .power_on_rst, .addr,
  .wdata, .write, .read, .rdata, .sleeping, .irq, .wake);

/* File: testbench/ext_pulse_source.sv */
// external count pulse source
`timescale 1ns/10ps
module ext_pulse_source (
  // count pin
  output logic ext_count_input
);
  initial ext_count_input = 1'b0;
  // pin rests low between bursts, so each burst begins with a rising edge
  task automatic pulses(input int n);
    repeat (n) begin
      #80 ext_count_input = 1'b1;
      #80 ext_count_input = 1'b0;
    end
  endtask
endmodule

/* File: testbench/testbench.sv */
// self-checking bench for the 16-bit timer
`timescale 1ns/10ps
module testbench;
  logic clock, sys_rst, power_on_rst, write, read, gate_input, sleeping, ext_count_input, irq, wake;
  logic [2:0] addr;
  logic [7:0] wdata, rdata;
  int num_errors = 0;
  int comparisons = 0;
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  ext_pulse_source ext_pulse_source_i (.ext_count_input);
  async_counter_timer16 async_counter_timer16_i (.clock, .sys_rst, .power_on_rst, .addr, .wdata, .write, .read,
    .rdata, .ext_count_input, .crystal_osc_input(1'b0), .cap_osc_input(1'b0), .gate_input, .sleeping, .irq, .wake);
  //////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    {write, addr, wdata} <= {1'b1, a, d};
    @(posedge clock);
    write <= 1'b0;
    @(posedge clock);
  endtask
  // optional write, then a read straight after it
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d, input logic [7:0] e);
    if (w) begin
      {write, addr, wdata} <= {1'b1, a, d};
      @(posedge clock);
      write <= 1'b0;
    end
    {read, addr} <= {1'b1, a};
    @(posedge clock);
    read <= 1'b0;
    #1 chk(rdata, e);
    @(posedge clock);
  endtask
  task automatic rst(input logic por);
    {power_on_rst, sys_rst} <= por ? 2'b10 : 2'b01;
    @(posedge clock);
    {power_on_rst, sys_rst} <= 2'b00;
    @(posedge clock);
  endtask
  task automatic stop_test;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  //////////////////////////////////////////
  task automatic t_regs;
    acc(0, 3'h0, 0, 8'h00);
    acc(1, 3'h0, 8'hFE, 8'hFC);
    acc(1, 3'h1, 8'hFF, 8'hE3);
    acc(0, 3'h7, 0, 8'h00);
    rst(0);
    acc(0, 3'h0, 0, 8'hFC);
    rst(1);
    acc(0, 3'h0, 0, 8'h00);
    acc(0, 3'h1, 0, 8'h00);
    $display("regs done");
  endtask
  task automatic t_count;
    sleeping <= 1'b1;
    for (int n = 0; n < 4; n++) begin
      wr(3'h0, 8'h00);
      wr(3'h3, 8'h00);
      wr(3'h2, 8'h00);
      wr(3'h0, 8'h85 | 8'(n << 4));
      #3 ext_pulse_source_i.pulses(8);
      repeat (4) @(posedge clock);
      acc(0, 3'h2, 0, 8'(8 >> n));
      acc(0, 3'h3, 0, 8'h00);
    end
    $display("count done");
  endtask
  task automatic t_ovf;
    wr(3'h0, 8'h00);
    wr(3'h3, 8'hFF);
    wr(3'h2, 8'hFF);
    wr(3'h4, 8'h01);
    wr(3'h0, 8'h85);
    #3 ext_pulse_source_i.pulses(1);
    repeat (4) @(posedge clock);
    acc(0, 3'h5, 0, 8'h01);
    #1 chk({7'h00, irq}, 8'h01);
    chk({7'h00, wake}, 8'h01);
    @(posedge clock);
    acc(0, 3'h3, 0, 8'h00);
    wr(3'h4, 8'h00);
    acc(0, 3'h5, 0, 8'h01);
    #1 chk({7'h00, irq}, 8'h00);
    @(posedge clock);
    acc(1, 3'h5, 8'h00, 8'h00);
    $display("overflow done");
  endtask
  task automatic t_gate;
    sleeping <= 1'b0;
    wr(3'h0, 8'h00);
    wr(3'h2, 8'h00);
    wr(3'h1, 8'hC0);
    wr(3'h0, 8'h41);
    repeat (5) @(posedge clock);
    acc(0, 3'h2, 0, 8'h00);
    wr(3'h0, 8'h40);
    wr(3'h1, 8'h00);
    gate_input <= 1'b1;
    acc(0, 3'h2, 0, 8'h00);
    wr(3'h0, 8'h41);
    wr(3'h0, 8'h40);
    acc(0, 3'h2, 0, 8'h02);
    $display("gate done");
  endtask
  //////////////////////////////////////////
  initial begin
    {sys_rst, power_on_rst, write, read, gate_input, sleeping} = 6'b110000;
    addr = 3'h0;
    wdata = 8'h00;
    repeat (8) @(posedge clock);
    {sys_rst, power_on_rst} <= 2'b00;
    @(posedge clock);
    t_regs;
    t_count;
    t_ovf;
    t_gate;
    stop_test;
  end
  initial begin
    #400000;
    num_errors++;
    stop_test;
  end
endmodule
